// ### design/swdt_pkg.sv
// Shared constants and helpers for the system watchdog timer
package swdt_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets on the peripheral bus)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_RANGE = 8'h04;
	localparam logic [7:0] OFF_COUNT = 8'h08;
	localparam logic [7:0] OFF_KICK = 8'h0c;
	localparam logic [7:0] OFF_STATE = 8'h10;
	localparam logic [7:0] OFF_CLEAR = 8'h14;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int CTL_EN_BIT = 0;
	localparam int CTL_RESP_BIT = 1;
	localparam int CTL_LEN_LSB = 2;
	localparam int CTL_W = 5;
	localparam logic [4:0] CTL_RESET = 5'h0a;
	localparam int RANGE_W = 4;
	localparam logic [3:0] RANGE_RESET = 4'h0;
	localparam logic [7:0] KICK_KEY = 8'h76;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [31:0] ONES_WORD = 32'hffff_ffff;
	localparam logic [4:0] RANGE_SHIFT_BASE = 5'h10;
	localparam logic [31:0] MIN_TIMEOUT = 32'h0000_ffff;

	// ----------------------------------------------------------------
	// Reset pulse lengths in clock cycles, one per length code
	// ----------------------------------------------------------------
	localparam int PULSE_W = 9;
	localparam logic [8:0] PULSE_LEN0 = 9'h002;
	localparam logic [8:0] PULSE_LEN1 = 9'h004;
	localparam logic [8:0] PULSE_LEN2 = 9'h008;
	localparam logic [8:0] PULSE_LEN3 = 9'h010;
	localparam logic [8:0] PULSE_LEN4 = 9'h020;
	localparam logic [8:0] PULSE_LEN5 = 9'h040;
	localparam logic [8:0] PULSE_LEN6 = 9'h080;
	localparam logic [8:0] PULSE_LEN7 = 9'h100;
	localparam logic [8:0] PULSE_ONE = 9'h001;

	// Timeout value 2^(16+n)-1 for range code n
	function automatic logic [31:0] swdt_timeout(input logic [3:0] code);
		swdt_timeout = ONES_WORD >> (RANGE_SHIFT_BASE - {1'b0, code});
	endfunction : swdt_timeout

	// Reset pulse width for a length code
	function automatic logic [8:0] swdt_pulse_len(input logic [2:0] code);
		case (code)
			3'h0: swdt_pulse_len = PULSE_LEN0;
			3'h1: swdt_pulse_len = PULSE_LEN1;
			3'h2: swdt_pulse_len = PULSE_LEN2;
			3'h3: swdt_pulse_len = PULSE_LEN3;
			3'h4: swdt_pulse_len = PULSE_LEN4;
			3'h5: swdt_pulse_len = PULSE_LEN5;
			3'h6: swdt_pulse_len = PULSE_LEN6;
			default: swdt_pulse_len = PULSE_LEN7;
		endcase
	endfunction : swdt_pulse_len

endpackage : swdt_pkg

// ### design/swdt_counter.sv
// Down counter with latched timeout value for the watchdog
`timescale 1ns/1ps
module swdt_counter
	import swdt_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic run_in, // Counter enabled
	input wire logic load_in, // Restart or enable edge
	input wire logic [3:0] range_in, // Timeout range code
	output logic [31:0] count_out, // Current count
	output logic timeout_out // Zero reached, no restart
);

	logic [31:0] count_q; // Running count
	logic [31:0] top_q; // Value latched at last restart
	logic at_zero; // Count is zero
	logic [31:0] new_top; // Value from the range code

	assign at_zero = (count_q == ZERO_WORD);
	assign new_top = swdt_timeout(range_in);
	// A restart in the zero cycle hides the timeout
	assign timeout_out = run_in && at_zero && !load_in;
	assign count_out = count_q;

	// ----------------------------------------------------------------
	// Counter update
	// ----------------------------------------------------------------
	// Range code only sampled on restart or enable edge
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_q <= ZERO_WORD;
			top_q <= MIN_TIMEOUT;
		end else if (run_in && load_in) begin
			count_q <= new_top;
			top_q <= new_top;
		end else if (run_in && at_zero) begin
			count_q <= top_q;
		end else if (run_in) begin
			count_q <= count_q - 32'h1;
		end
	end

endmodule : swdt_counter

// ### design/swdt_pulse.sv
// System reset pulse stretcher for the watchdog
`timescale 1ns/1ps
module swdt_pulse
	import swdt_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic start_in, // Request a reset pulse
	input wire logic [2:0] len_code_in, // Pulse length code
	output logic active_out // Reset pulse, from a flop
);

	logic active_q; // Pulse in progress
	logic [8:0] left_q; // Cycles left after this one

	assign active_out = active_q;

	// ----------------------------------------------------------------
	// Pulse timer
	// ----------------------------------------------------------------
	// New starts ignored while a pulse runs, so nothing cuts it short
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			active_q <= 1'b0;
			left_q <= '0;
		end else if (start_in && !active_q) begin
			active_q <= 1'b1;
			left_q <= swdt_pulse_len(len_code_in) - PULSE_ONE;
		end else if (active_q) begin
			if (left_q == '0) begin
				active_q <= 1'b0;
			end else begin
				left_q <= left_q - PULSE_ONE;
			end
		end
	end

endmodule : swdt_pulse

// ### design/swdt_top.sv
// System watchdog timer with its peripheral bus slave
//
// Notes on behaviour
// - Enabled counter drops by one each clock
// - At zero reload timeout and keep counting
// - Only key 0x76 at kick register restarts
// - Mode one: interrupt, then reset if pending
// - Mode zero: every timeout asserts system reset
// - Restart at zero cycle raises no interrupt
// - Reset pulse runs full length, restart ignored
// - Length code picks 2 to 256 cycles
// - Control bit zero enables, reset disabled
// - Range code n gives 2^(16+n)-1
// - New range applies at next restart or enable edge only
// - Count read is one coherent snapshot
// - Valid restart clears pending interrupt
// - Kick register reads as zero
// - Status bit zero shows interrupt state
// - Clear register clears pending interrupt
// - Clearing interrupt leaves counter running on
// - 32-bit counter on bus clock, 32-bit bus
`timescale 1ns/1ps
module swdt_top
	import swdt_pkg::*;
(
	input wire logic clock_in, // Bus clock
	input wire logic reset_n_in, // Async reset, active low
	input wire logic psel_in, // Slave select
	input wire logic penable_in, // Access phase
	input wire logic pwrite_in, // Write when high
	input wire logic [7:0] paddr_in, // Byte address
	input wire logic [31:0] pwdata_in, // Write data
	output logic [31:0] prdata_out, // Read data
	output logic pready_out, // Transfer done
	output logic pslverr_out, // Unmapped address
	output logic wdt_irq_out, // Watchdog interrupt
	output logic sys_reset_out // System reset request
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic setup_w; // Setup phase
	logic access_w; // Access phase
	logic wr_w; // Write in access phase
	logic rd_w; // Read in access phase
	logic hit_ctl; // Control register selected
	logic hit_rng; // Range register selected
	logic hit_cnt; // Count register selected
	logic hit_kick; // Kick register selected
	logic hit_st; // State register selected
	logic hit_clr; // Clear register selected
	logic hit_any; // Any mapped register

	assign setup_w = psel_in && !penable_in;
	assign access_w = psel_in && penable_in;
	assign wr_w = access_w && pwrite_in;
	assign rd_w = access_w && !pwrite_in;
	assign hit_ctl = (paddr_in == OFF_CONTROL);
	assign hit_rng = (paddr_in == OFF_RANGE);
	assign hit_cnt = (paddr_in == OFF_COUNT);
	assign hit_kick = (paddr_in == OFF_KICK);
	assign hit_st = (paddr_in == OFF_STATE);
	assign hit_clr = (paddr_in == OFF_CLEAR);
	assign hit_any = hit_ctl || hit_rng || hit_cnt || hit_kick
		|| hit_st || hit_clr;

	// Zero wait states; error only on unmapped addresses
	assign pready_out = 1'b1;
	assign pslverr_out = access_w && !hit_any;

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic [4:0] ctl_q; // Enable, mode, pulse length
	logic [3:0] rng_q; // Timeout range code
	logic en_prev_q; // Enable seen last cycle

	// Control and range writes
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctl_q <= CTL_RESET;
			rng_q <= RANGE_RESET;
		end else begin
			if (wr_w && hit_ctl) begin
				ctl_q <= pwdata_in[CTL_W-1:0];
			end
			if (wr_w && hit_rng) begin
				rng_q <= pwdata_in[RANGE_W-1:0];
			end
		end
	end

	// Enable history for the load on the enabling edge
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			en_prev_q <= 1'b0;
		end else begin
			en_prev_q <= ctl_q[CTL_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Control fields and events
	// ----------------------------------------------------------------
	logic wdt_en; // Watchdog running
	logic resp_irq; // Interrupt first on timeout
	logic [2:0] len_code; // Pulse length code
	logic kick_w; // Valid restart this cycle
	logic eoi_rd; // Clear register read
	logic load_w; // Counter load request
	logic tmo_w; // Timeout this cycle
	logic [31:0] count_w; // Counter value
	logic int_q; // Pending interrupt
	logic rst_start; // Begin a reset pulse

	assign wdt_en = ctl_q[CTL_EN_BIT];
	assign resp_irq = ctl_q[CTL_RESP_BIT];
	assign len_code = ctl_q[CTL_LEN_LSB+2:CTL_LEN_LSB];
	// Only the exact key restarts the counter
	assign kick_w = wr_w && hit_kick
		&& (pwdata_in[7:0] == KICK_KEY);
	assign eoi_rd = rd_w && hit_clr;
	assign load_w = kick_w || (wdt_en && !en_prev_q);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	swdt_counter u_counter (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.run_in(wdt_en),
		.load_in(load_w),
		.range_in(rng_q),
		.count_out(count_w),
		.timeout_out(tmo_w)
	);

	// ----------------------------------------------------------------
	// Response to a timeout
	// ----------------------------------------------------------------
	// Mode zero resets at once; mode one resets only if still pending
	assign rst_start = tmo_w
		&& (!resp_irq || int_q);

	// Interrupt flag: a timeout set wins over a same-cycle clear
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			int_q <= 1'b0;
		end else if (tmo_w && resp_irq) begin
			int_q <= 1'b1;
		end else if (kick_w || eoi_rd) begin
			int_q <= 1'b0;
		end
	end

	assign wdt_irq_out = int_q;

	// ----------------------------------------------------------------
	// Reset pulse
	// ----------------------------------------------------------------
	swdt_pulse u_pulse (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.start_in(rst_start),
		.len_code_in(len_code),
		.active_out(sys_reset_out)
	);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [31:0] rd_mux; // Selected read word
	logic [31:0] prdata_q; // Registered read data

	// Kick and clear registers read as zero
	assign rd_mux = hit_ctl ? {27'h0, ctl_q}
		: hit_rng ? {28'h0, rng_q}
		: hit_cnt ? count_w
		: hit_st ? {31'h0, int_q}
		: ZERO_WORD;

	// Whole word captured in one edge, so the count is coherent
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prdata_q <= ZERO_WORD;
		end else if (setup_w && !pwrite_in) begin
			prdata_q <= rd_mux;
		end
	end

	assign prdata_out = prdata_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);

	// Running counter steps down by one
	property p_count_dec;
		wdt_en && !load_w && count_w != ZERO_WORD
			|=> count_w == $past(count_w) - 32'h1;
	endproperty
	a_count_dec: assert property (p_count_dec)
		else $error("counter did not decrement");

	// Zero wraps to a timeout value and keeps going
	property p_wrap;
		wdt_en && !load_w && count_w == ZERO_WORD
			|=> count_w[15:0] == MIN_TIMEOUT[15:0]
			##1 ($past(load_w) || !$past(wdt_en)
			|| count_w[15:0] == 16'hfffe);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("counter did not wrap and continue");

	// Valid kick loads the value of the current range code
	property p_kick;
		kick_w && wdt_en |=> count_w == swdt_timeout($past(rng_q));
	endproperty
	a_kick: assert property (p_kick)
		else $error("kick did not load timeout value");

	// Mode one: first timeout raises the interrupt
	property p_irq_first;
		tmo_w && resp_irq && !int_q && !sys_reset_out
			|=> wdt_irq_out && !sys_reset_out;
	endproperty
	a_irq_first: assert property (p_irq_first)
		else $error("first timeout did not raise interrupt");

	// Mode zero: timeout goes straight to reset
	property p_mode0;
		tmo_w && !resp_irq && !sys_reset_out
			|=> sys_reset_out && !$rose(wdt_irq_out);
	endproperty
	a_mode0: assert property (p_mode0)
		else $error("timeout in mode zero gave no reset");

	// Restart in the zero cycle raises no interrupt
	property p_kick_zero;
		kick_w && wdt_en && count_w == ZERO_WORD |=> !wdt_irq_out;
	endproperty
	a_kick_zero: assert property (p_kick_zero)
		else $error("interrupt raised despite restart");

	// A reset pulse lasts at least the shortest length
	property p_pulse_hold;
		$rose(sys_reset_out) |-> sys_reset_out[*2];
	endproperty
	a_pulse_hold: assert property (p_pulse_hold)
		else $error("reset pulse too short");

	// Reading the clear register drops the interrupt, count runs on
	property p_eoi;
		eoi_rd && !tmo_w && !load_w && wdt_en && count_w != ZERO_WORD
			|=> !wdt_irq_out && count_w == $past(count_w) - 32'h1;
	endproperty
	a_eoi: assert property (p_eoi)
		else $error("clear read misbehaved");

	// Kick register always reads zero
	property p_kick_read;
		setup_w && !pwrite_in && hit_kick |=> prdata_out == ZERO_WORD;
	endproperty
	a_kick_read: assert property (p_kick_read)
		else $error("kick register read nonzero");

	// Status read shows the interrupt flag
	property p_status;
		setup_w && !pwrite_in && hit_st
			|=> prdata_out == {31'h0, $past(int_q)};
	endproperty
	a_status: assert property (p_status)
		else $error("status read wrong");

	// Wrong key leaves the count running on
	property p_bad_key;
		wr_w && hit_kick && pwdata_in[7:0] != KICK_KEY && wdt_en
			&& !load_w && count_w != ZERO_WORD
			|=> count_w == $past(count_w) - 32'h1;
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("wrong key restarted the counter");

	// Mode one: timeout with interrupt pending starts the reset
	property p_irq_second;
		tmo_w && resp_irq && int_q && !sys_reset_out
			|=> sys_reset_out && wdt_irq_out;
	endproperty
	a_irq_second: assert property (p_irq_second)
		else $error("second timeout gave no reset");

	// A valid kick drops a pending interrupt
	property p_kick_clear;
		kick_w |=> !wdt_irq_out;
	endproperty
	a_kick_clear: assert property (p_kick_clear)
		else $error("kick left interrupt pending");

	// Range write does not touch the running count
	property p_range_hold;
		wr_w && hit_rng && wdt_en && !load_w && count_w != ZERO_WORD
			|=> count_w == $past(count_w) - 32'h1;
	endproperty
	a_range_hold: assert property (p_range_hold)
		else $error("range write changed the count");

	// Enabling loads the timeout of the current range code
	property p_enable_load;
		wdt_en && !en_prev_q |=> count_w == swdt_timeout($past(rng_q));
	endproperty
	a_enable_load: assert property (p_enable_load)
		else $error("enable did not load timeout value");

	// Disabled counter holds its value
	property p_disabled_hold;
		!wdt_en |=> count_w == $past(count_w);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold)
		else $error("disabled counter moved");

	// Helper: high cycles of the running reset pulse and its set width
	logic [8:0] pulse_run_q; // Pulse cycles so far, this one included
	logic [8:0] pulse_want_q; // Width chosen at the start

	// Count reset pulse cycles from the start edge
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pulse_run_q <= '0;
			pulse_want_q <= '0;
		end else if (rst_start && !sys_reset_out) begin
			pulse_run_q <= PULSE_ONE;
			pulse_want_q <= swdt_pulse_len(len_code);
		end else if (sys_reset_out) begin
			pulse_run_q <= pulse_run_q + PULSE_ONE;
		end
	end

	// Pulse stays up until its width is reached, kicks or not
	property p_pulse_long;
		sys_reset_out && pulse_run_q < pulse_want_q |=> sys_reset_out;
	endproperty
	a_pulse_long: assert property (p_pulse_long)
		else $error("reset pulse cut short");

	// Pulse ends right after its width
	property p_pulse_end;
		sys_reset_out && pulse_run_q == pulse_want_q |=> !sys_reset_out;
	endproperty
	a_pulse_end: assert property (p_pulse_end)
		else $error("reset pulse too long");

endmodule : swdt_top

// ### dv/swdt_reset_ctrl_model.sv
// Reset controller model that watches the watchdog reset request
`timescale 1ns/1ps
module swdt_reset_ctrl_model (
	input wire logic clock_in, // Bus clock
	input wire logic reset_n_in, // Async reset, active low
	input wire logic sys_reset_in, // Reset request from the watchdog
	output int pulse_count_out, // Completed reset pulses
	output int last_width_out // Width of the last pulse in cycles
);
	int width_q; // Cycles of the pulse now running

	// ----------------------------------------------------------------
	// Pulse measurement
	// ----------------------------------------------------------------
	// Count high cycles, log the width when the request drops
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			width_q <= 0;
			pulse_count_out <= 0;
			last_width_out <= 0;
		end else if (sys_reset_in === 1'b1) begin
			width_q <= width_q + 1;
		end else if (width_q != 0) begin
			pulse_count_out <= pulse_count_out + 1;
			last_width_out <= width_q;
			width_q <= 0;
		end
	end
endmodule : swdt_reset_ctrl_model

// ### dv/tb_system_watchdog_timer.sv
// Self-checking testbench for the system watchdog timer
`timescale 1ns/1ps
module tb_system_watchdog_timer
	import swdt_pkg::*;
;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0000_0000;
	logic [31:0] prdata_out;
	logic pready_out;
	logic pslverr_out;
	logic wdt_irq_out;
	logic sys_reset_out;
	int pulse_count; // Reset pulses seen by the controller model
	int failures = 0;
	int tests_run = 0;
	int cyc = 0; // Free-running cycle count
	int t_acc; // Cycle of the last write access edge
	int t_set; // Cycle of the last read setup edge
	logic [31:0] rd_v; // Last read data
	logic rd_err; // Last error response
	logic [7:0] seed = 8'h3f; // Random state
	longint tmo[16]; // Model timeout per range code
	longint t0;
	logic [31:0] v1;
	logic [7:0] key;

	// ----------------------------------------------------------------
	// Design, far side and clock
	// ----------------------------------------------------------------
	swdt_top swdt_top_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.wdt_irq_out(wdt_irq_out), .sys_reset_out(sys_reset_out));
	swdt_reset_ctrl_model swdt_reset_ctrl_model_i (.clock_in(clock_in),
		.reset_n_in(reset_n_in), .sys_reset_in(sys_reset_out),
		.pulse_count_out(pulse_count), .last_width_out());

	// Clock toggles every half period
	always #5 clock_in = ~clock_in;

	// Cycle count with a hang ceiling
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			failures++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Next random byte from the shift register
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// Bus write, setup then access, held until ready
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clock_in);
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = {3'b101, a, d};
		@(negedge clock_in);
		penable_in = 1'b1;
		@(posedge clock_in);
		while (pready_out !== 1'b1) begin
			@(posedge clock_in);
		end
		t_acc = cyc;
		@(negedge clock_in);
		{psel_in, penable_in} = 2'b00;
	endtask : bus_wr

	// Bus read, data and error taken at the access edge
	task automatic bus_rd(input logic [7:0] a);
		@(negedge clock_in);
		{psel_in, penable_in, pwrite_in, paddr_in} = {3'b100, a};
		@(posedge clock_in);
		t_set = cyc;
		@(negedge clock_in);
		penable_in = 1'b1;
		@(posedge clock_in);
		while (pready_out !== 1'b1) begin
			@(posedge clock_in);
		end
		rd_v = prdata_out;
		rd_err = pslverr_out;
		@(negedge clock_in);
		{psel_in, penable_in} = 2'b00;
	endtask : bus_rd

	// Compare a register word
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %0t word %h want %h", $time, got, exp);
		end
	endtask : chk32

	// Compare a flag
	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %0t flag %b want %b", $time, got, exp);
		end
	endtask : chk1

	// Verdict and end of run
	task automatic results();
		if (failures == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		for (int n = 0; n < 16; n++) begin
			tmo[n] = (64'h1 << (16 + n)) - 1;
		end
		repeat (20) @(negedge clock_in);
		reset_n_in = 1'b1;
		// Reset values of the whole map
		for (int i = 0; i < 6; i++) begin
			bus_rd(8'(i * 4));
			chk32(rd_v, (i == 0) ? 32'h0000_000a : 32'h0000_0000);
		end
		bus_rd(8'h18);
		chk1(rd_err, 1'b1);
		chk1(pready_out, 1'b1);
		bus_wr(OFF_COUNT, 32'h0000_1234);
		bus_rd(OFF_COUNT);
		chk32(rd_v, 32'h0000_0000);
		// Enable with every control bit set
		bus_wr(OFF_CONTROL, 32'hffff_ffff);
		t0 = t_acc;
		bus_rd(OFF_CONTROL);
		chk32(rd_v, 32'h0000_001f);
		// Enable is seen one cycle late, then the load takes a cycle
		bus_rd(OFF_COUNT);
		chk32(rd_v, 32'(tmo[0] - (t_set - t0 - 2)));
		v1 = rd_v;
		t0 = t_set;
		bus_rd(OFF_COUNT);
		chk32(rd_v, v1 - 32'(t_set - t0));
		// Disabled counter holds still
		bus_wr(OFF_CONTROL, 32'h0000_000a);
		bus_rd(OFF_COUNT);
		v1 = rd_v;
		bus_rd(OFF_COUNT);
		chk32(rd_v, v1);
		bus_wr(OFF_CONTROL, 32'h0000_000b);
		// Range codes 1 to 15, a wrong key first, then the real one
		for (int n = 1; n < 16; n++) begin
			bus_wr(OFF_RANGE, 32'(n));
			seed = lfsr(seed);
			key = (seed == KICK_KEY) ? 8'h77 : seed;
			bus_wr(OFF_KICK, {24'h00_0000, key});
			bus_rd(OFF_COUNT);
			chk1(rd_v <= tmo[n - 1], 1'b1);
			bus_wr(OFF_KICK, 32'h0000_0076);
			t0 = t_acc;
			// Kick loads at its access edge
			bus_rd(OFF_COUNT);
			chk32(rd_v, 32'(tmo[n] - (t_set - t0 - 1)));
			chk1(wdt_irq_out, 1'b0);
		end
		bus_rd(OFF_KICK);
		chk32(rd_v, 32'h0000_0000);
		// Shortest range, then wait out one timeout
		bus_wr(OFF_RANGE, 32'h0000_0000);
		bus_wr(OFF_KICK, 32'h0000_0076);
		t0 = t_acc;
		while (wdt_irq_out !== 1'b1 && cyc - t0 < 70000) begin
			@(negedge clock_in);
		end
		chk32(32'(cyc - t0), 32'(tmo[0] + 2));
		chk1(sys_reset_out, 1'b0);
		bus_rd(OFF_STATE);
		chk32(rd_v, 32'h0000_0001);
		bus_rd(OFF_COUNT);
		chk1(rd_v > tmo[0] - 40, 1'b1);
		v1 = rd_v;
		t0 = t_set;
		bus_rd(OFF_CLEAR);
		chk32(rd_v, 32'h0000_0000);
		chk1(wdt_irq_out, 1'b0);
		bus_rd(OFF_COUNT);
		chk32(rd_v, v1 - 32'(t_set - t0));
		chk32(32'(pulse_count), 32'h0000_0000);
		// Reset in mid-run returns the map to its reset state
		@(negedge clock_in);
		reset_n_in = 1'b0;
		repeat (2) @(negedge clock_in);
		reset_n_in = 1'b1;
		bus_rd(OFF_CONTROL);
		chk32(rd_v, 32'h0000_000a);
		bus_rd(OFF_COUNT);
		chk32(rd_v, 32'h0000_0000);
		chk1(wdt_irq_out, 1'b0);
		results();
	end
endmodule : tb_system_watchdog_timer
